// *** psim_pkg.sv ***
package psim_pkg;

  // bus geometry
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IDX_W    = ADDR_W - 2;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 16;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BASE_STATUS = 10'h001;
  localparam logic [IDX_W-1:0] IDX_STATUS_TWO  = 10'h011;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 10'h012;
  localparam logic [IDX_W-1:0] IDX_CHANGE      = 10'h013;
  localparam logic [IDX_W-1:0] IDX_ERR_SRC     = 10'h015;

  // base status register fields
  localparam int unsigned BS_NEG_DONE = 5;

  // second status register fields
  localparam int unsigned ST_SPEED_100 = 14;
  localparam int unsigned ST_TX_ACT    = 13;
  localparam int unsigned ST_RX_ACT    = 12;
  localparam int unsigned ST_COLLISION = 11;
  localparam int unsigned ST_LINK_UP   = 10;
  localparam int unsigned ST_FULL_DPX  = 9;
  localparam int unsigned ST_NEG_MODE  = 8;
  localparam int unsigned ST_NEG_DONE  = 7;
  localparam int unsigned ST_POL_REV   = 5;
  localparam int unsigned ST_PAUSE     = 4;
  localparam int unsigned ST_ERROR     = 3;

  // interrupt mask register fields
  localparam int unsigned IM_NEG_DONE  = 7;
  localparam int unsigned IM_SPEED     = 6;
  localparam int unsigned IM_DUPLEX    = 5;
  localparam int unsigned IM_LINK      = 4;
  localparam int unsigned IM_GLOBAL_EN = 1;
  localparam int unsigned IM_TEST_FORCE = 0;

  // change register fields
  localparam int unsigned CH_NEG_DONE = 7;
  localparam int unsigned CH_SPEED    = 6;
  localparam int unsigned CH_DUPLEX   = 5;
  localparam int unsigned CH_LINK     = 4;
  localparam int unsigned CH_IRQ_PEND = 2;

  // change flag vector layout
  localparam int unsigned CHG_N      = 4;
  localparam int unsigned CHG_NEG    = 3;
  localparam int unsigned CHG_SPEED  = 2;
  localparam int unsigned CHG_DUPLEX = 1;
  localparam int unsigned CHG_LINK   = 0;

  // error source vector layout, also its register layout
  localparam int unsigned ERR_N       = 3;
  localparam int unsigned ERR_REMOTE  = 2;
  localparam int unsigned ERR_JABBER  = 1;
  localparam int unsigned ERR_PARDET  = 0;

  // reset values and writable bits
  localparam logic [REG_W-1:0]  STATUS_TWO_RESET = 16'h0000;
  localparam logic [REG_W-1:0]  IRQ_MASK_RESET   = 16'h0000;
  localparam logic [REG_W-1:0]  IRQ_MASK_WMASK   = 16'h00F3;
  localparam logic [DATA_W-1:0] RDATA_ZERO       = 32'h0000_0000;

endpackage

// *** psim_sticky.sv ***
`timescale 1ns/10ps
`default_nettype none

// sticky event flags: a set in the same cycle as a clear wins
module psim_sticky #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // events and clears
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clr_bits,
  // held flags
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // clear first, then set so a fresh event survives
  always_comb begin
    nxt_flags = (flags_ff & ~clr_bits) | set_bits;
  end

  // flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

endmodule

`default_nettype wire

// *** psim_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - speed bit high in 100 Mbit mode
// - transmit bit high while sending
// - receive bit high while receiving
// - live collision, link and duplex bits
// - mode bit high under auto-negotiation
// - negotiation complete bit set when finished
// - completion bit mirrors base status bit
// - polarity bit high when pair reversed
// - pause bit shows pause capability
// - error bit set on fault conditions
// - error cleared by reading source register
// - negotiation done mask gates its interrupt
// - speed mask gates speed interrupt
// - duplex mask gates duplex interrupt
// - link mask gates link interrupt
// - global enable gates all change flag interrupts, not the test force
// - test bit forces interrupt output low
// - change flags clear on register read
module psim_regs (
  // apb slave
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [psim_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [psim_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [psim_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // phy core status
  input  wire logic                          speed_100,
  input  wire logic                          tx_active,
  input  wire logic                          rx_active,
  input  wire logic                          collision,
  input  wire logic                          link_up,
  input  wire logic                          full_duplex,
  input  wire logic                          neg_mode,
  input  wire logic                          neg_done,
  input  wire logic                          polarity_rev,
  input  wire logic                          pause_cap,
  // phy core fault events
  input  wire logic                          remote_fault,
  input  wire logic                          jabber,
  input  wire logic                          par_det_fault,
  // management interrupt
  output logic                               mgmt_irq_n
);

  // address match on an aligned word at the given index
  function automatic logic addr_hit(
    input logic [psim_pkg::ADDR_W-1:0] addr,
    input logic [psim_pkg::IDX_W-1:0]  idx
  );
    addr_hit = (addr[psim_pkg::WORD_LSB-1:0] == '0) &&
               (addr[psim_pkg::ADDR_W-1:psim_pkg::WORD_LSB] == idx);
  endfunction

  // byte lane merge of write data into a 16 bit register
  function automatic logic [psim_pkg::REG_W-1:0] lane_merge(
    input logic [psim_pkg::REG_W-1:0]  old_val,
    input logic [psim_pkg::DATA_W-1:0] wdata,
    input logic [3:0]                  strb,
    input logic [psim_pkg::REG_W-1:0]  wmask
  );
    logic [psim_pkg::REG_W-1:0] lane_en;
    lane_en    = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    lane_merge = (old_val & ~lane_en) | (wdata[psim_pkg::REG_W-1:0] & lane_en);
  endfunction

  // a status bit that differs from its registered image marks a change
  function automatic logic bit_moved(
    input logic [psim_pkg::REG_W-1:0] now_val,
    input logic [psim_pkg::REG_W-1:0] old_val,
    input int unsigned                pos
  );
    bit_moved = (now_val[pos] != old_val[pos]);
  endfunction

  // state
  logic [psim_pkg::DATA_W-1:0] prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic                        mgmt_irq_n_ff;
  logic [psim_pkg::REG_W-1:0]  status_two_ff;
  logic [psim_pkg::REG_W-1:0]  irq_mask_ff;
  logic [psim_pkg::CHG_N-1:0]  cap_chg_ff;
  logic [psim_pkg::ERR_N-1:0]  cap_err_ff;

  // next values and decode
  logic [psim_pkg::REG_W-1:0]  nxt_status_two;
  logic [psim_pkg::DATA_W-1:0] nxt_prdata;
  logic                        nxt_pslverr;
  logic                        nxt_mgmt_irq_n;
  logic [psim_pkg::CHG_N-1:0]  nxt_cap_chg;
  logic [psim_pkg::ERR_N-1:0]  nxt_cap_err;
  logic                        capture;
  logic                        complete;
  logic                        hit_base;
  logic                        hit_st2;
  logic                        hit_mask;
  logic                        hit_chg;
  logic                        hit_err;
  logic                        mapped;
  logic [psim_pkg::CHG_N-1:0]  chg_set;
  logic [psim_pkg::CHG_N-1:0]  chg_clr;
  logic [psim_pkg::CHG_N-1:0]  chg_flags;
  logic [psim_pkg::CHG_N-1:0]  chg_masks;
  logic [psim_pkg::ERR_N-1:0]  err_set;
  logic [psim_pkg::ERR_N-1:0]  err_clr;
  logic [psim_pkg::ERR_N-1:0]  err_flags;
  logic                        irq_cause;

  // access phase splits into a capture cycle and a completion cycle
  assign capture  = psel && penable && !pready_ff;
  assign complete = psel && penable && pready_ff;

  // register decode
  assign hit_base = addr_hit(paddr, psim_pkg::IDX_BASE_STATUS);
  assign hit_st2  = addr_hit(paddr, psim_pkg::IDX_STATUS_TWO);
  assign hit_mask = addr_hit(paddr, psim_pkg::IDX_IRQ_MASK);
  assign hit_chg  = addr_hit(paddr, psim_pkg::IDX_CHANGE);
  assign hit_err  = addr_hit(paddr, psim_pkg::IDX_ERR_SRC);
  assign mapped   = hit_base || hit_st2 || hit_mask || hit_chg || hit_err;

  // live status image, reserved bits stay zero
  always_comb begin
    nxt_status_two = psim_pkg::STATUS_TWO_RESET;
    nxt_status_two[psim_pkg::ST_SPEED_100] = speed_100;
    nxt_status_two[psim_pkg::ST_TX_ACT]    = tx_active;
    nxt_status_two[psim_pkg::ST_RX_ACT]    = rx_active;
    nxt_status_two[psim_pkg::ST_COLLISION] = collision;
    nxt_status_two[psim_pkg::ST_LINK_UP]   = link_up;
    nxt_status_two[psim_pkg::ST_FULL_DPX]  = full_duplex;
    nxt_status_two[psim_pkg::ST_NEG_MODE]  = neg_mode;
    nxt_status_two[psim_pkg::ST_NEG_DONE]  = neg_done;
    nxt_status_two[psim_pkg::ST_POL_REV]   = polarity_rev;
    nxt_status_two[psim_pkg::ST_PAUSE]     = pause_cap;
    nxt_status_two[psim_pkg::ST_ERROR]     = |err_flags;
  end

  // status image register, one cycle behind the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_two_ff <= psim_pkg::STATUS_TWO_RESET;
    end else begin
      status_two_ff <= nxt_status_two;
    end
  end

  // change events from the status image
  always_comb begin
    chg_set = '0;
    chg_set[psim_pkg::CHG_NEG] = nxt_status_two[psim_pkg::ST_NEG_DONE] &&
                                 !status_two_ff[psim_pkg::ST_NEG_DONE];
    chg_set[psim_pkg::CHG_SPEED]  = bit_moved(nxt_status_two, status_two_ff,
                                              psim_pkg::ST_SPEED_100);
    chg_set[psim_pkg::CHG_DUPLEX] = bit_moved(nxt_status_two, status_two_ff,
                                              psim_pkg::ST_FULL_DPX);
    chg_set[psim_pkg::CHG_LINK]   = bit_moved(nxt_status_two, status_two_ff,
                                              psim_pkg::ST_LINK_UP);
  end

  // fault events feeding the error summary
  always_comb begin
    err_set = '0;
    err_set[psim_pkg::ERR_REMOTE] = remote_fault;
    err_set[psim_pkg::ERR_JABBER] = jabber;
    err_set[psim_pkg::ERR_PARDET] = par_det_fault;
  end

  // only the flags snapshotted with the read data are cleared, the negotiation flag too though bit 7 reads live status
  assign chg_clr = complete ? cap_chg_ff : '0;
  assign err_clr = complete ? cap_err_ff : '0;

  // change flags since the last read of the change register
  psim_sticky #(
    .WIDTH (psim_pkg::CHG_N)
  ) u_chg_flags (
    .clk      (pclk),
    .rst_n    (presetn),
    .set_bits (chg_set),
    .clr_bits (chg_clr),
    .flags    (chg_flags)
  );

  // latched fault conditions, cleared through their own register
  psim_sticky #(
    .WIDTH (psim_pkg::ERR_N)
  ) u_err_flags (
    .clk      (pclk),
    .rst_n    (presetn),
    .set_bits (err_set),
    .clr_bits (err_clr),
    .flags    (err_flags)
  );

  // interrupt mask register, reserved bits never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= psim_pkg::IRQ_MASK_RESET;
    end else if (complete && pwrite && hit_mask) begin
      irq_mask_ff <= lane_merge(irq_mask_ff, pwdata, pstrb,
                                psim_pkg::IRQ_MASK_WMASK);
    end
  end

  // mask bits lined up with the change flag vector
  always_comb begin
    chg_masks = '0;
    chg_masks[psim_pkg::CHG_NEG]    = irq_mask_ff[psim_pkg::IM_NEG_DONE];
    chg_masks[psim_pkg::CHG_SPEED]  = irq_mask_ff[psim_pkg::IM_SPEED];
    chg_masks[psim_pkg::CHG_DUPLEX] = irq_mask_ff[psim_pkg::IM_DUPLEX];
    chg_masks[psim_pkg::CHG_LINK]   = irq_mask_ff[psim_pkg::IM_LINK];
  end

  // interrupt cause: enabled masked flags, or the test force
  always_comb begin
    irq_cause = irq_mask_ff[psim_pkg::IM_GLOBAL_EN] &&
                (|(chg_flags & chg_masks));
    nxt_mgmt_irq_n = !(irq_cause ||
                       irq_mask_ff[psim_pkg::IM_TEST_FORCE]);
  end

  // active low interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_irq_n_ff <= 1'b1;
    end else begin
      mgmt_irq_n_ff <= nxt_mgmt_irq_n;
    end
  end

  // read data mux
  always_comb begin
    nxt_prdata  = psim_pkg::RDATA_ZERO;
    nxt_pslverr = !mapped;
    if (hit_base) begin
      nxt_prdata[psim_pkg::BS_NEG_DONE] = status_two_ff[psim_pkg::ST_NEG_DONE];
    end
    if (hit_st2) begin
      nxt_prdata[psim_pkg::REG_W-1:0] = status_two_ff;
    end
    if (hit_mask) begin
      nxt_prdata[psim_pkg::REG_W-1:0] = irq_mask_ff & psim_pkg::IRQ_MASK_WMASK;
    end
    if (hit_chg) begin
      nxt_prdata[psim_pkg::CH_NEG_DONE] = status_two_ff[psim_pkg::ST_NEG_DONE];
      nxt_prdata[psim_pkg::CH_SPEED]    = chg_flags[psim_pkg::CHG_SPEED];
      nxt_prdata[psim_pkg::CH_DUPLEX]   = chg_flags[psim_pkg::CHG_DUPLEX];
      nxt_prdata[psim_pkg::CH_LINK]     = chg_flags[psim_pkg::CHG_LINK];
      nxt_prdata[psim_pkg::CH_IRQ_PEND] = !mgmt_irq_n_ff;
    end
    if (hit_err) begin
      nxt_prdata[psim_pkg::ERR_N-1:0] = err_flags;
    end
  end

  // change flags a read will clear, as the reader sees them
  always_comb begin
    nxt_cap_chg = '0;
    if (!pwrite && hit_chg) begin
      nxt_cap_chg = chg_flags;
    end
  end

  // error flags a read will clear, as the reader sees them
  always_comb begin
    nxt_cap_err = '0;
    if (!pwrite && hit_err) begin
      nxt_cap_err = err_flags;
    end
  end

  // change clear snapshot, frozen at capture, dropped at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_chg_ff <= '0;
    end else if (capture) begin
      cap_chg_ff <= nxt_cap_chg;
    end else if (complete) begin
      cap_chg_ff <= '0;
    end
  end

  // error clear snapshot, frozen at capture, dropped at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_err_ff <= '0;
    end else if (capture) begin
      cap_err_ff <= nxt_cap_err;
    end else if (complete) begin
      cap_err_ff <= '0;
    end
  end

  // apb handshake: one wait cycle, ready stands for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= capture;
    end
  end

  // read data stands with pready only, zero on writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= psim_pkg::RDATA_ZERO;
    end else if (capture && !pwrite) begin
      prdata_ff <= nxt_prdata;
    end else begin
      prdata_ff <= psim_pkg::RDATA_ZERO;
    end
  end

  // slave error stands with pready only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_ff <= 1'b0;
    end else if (capture) begin
      pslverr_ff <= nxt_pslverr;
    end else begin
      pslverr_ff <= 1'b0;
    end
  end

  // outputs straight from flops
  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign mgmt_irq_n = mgmt_irq_n_ff;

endmodule

`default_nettype wire

// *** psim_regs_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// port-level checker for the status and interrupt mask register block
module psim_regs_asserts (
  // apb slave
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // phy core status
  input wire logic        speed_100,
  input wire logic        tx_active,
  input wire logic        rx_active,
  input wire logic        collision,
  input wire logic        link_up,
  input wire logic        full_duplex,
  input wire logic        neg_mode,
  input wire logic        neg_done,
  input wire logic        polarity_rev,
  input wire logic        pause_cap,
  // phy core faults
  input wire logic        remote_fault,
  input wire logic        jabber,
  input wire logic        par_det_fault,
  // interrupt
  input wire logic        mgmt_irq_n
);
  logic [9:0] st;
  logic [9:0] st_d1_ff;
  logic [9:0] st_d2_ff;
  logic       rd_ok;

  // status inputs in register order, kept two samples back so reads see settled values
  assign st = {speed_100, tx_active, rx_active, collision, link_up, full_duplex,
               neg_mode, neg_done, polarity_rev, pause_cap};
  assign rd_ok = pready && !pwrite && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_d1_ff <= '0;
      st_d2_ff <= '0;
    end else begin
      st_d1_ff <= st;
      st_d2_ff <= st_d1_ff;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing one cycle after capture");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata nonzero outside a completion");
  a_status_live_bits:
    assert property (rd_ok && paddr == 12'h044 && st == st_d1_ff && st_d1_ff == st_d2_ff
      |-> prdata[14:4] == {st[9:2], 1'b0, st[1:0]})
    else $error("status two bits differ from core inputs");
  a_status_reserved_zero:
    assert property (rd_ok && paddr == 12'h044 |-> (prdata & 32'hFFFF_8047) == 32'h0000_0000)
    else $error("status two reserved bit set");
  a_neg_done_mirror:
    assert property (rd_ok && paddr == 12'h004 && st[2] == st_d1_ff[2] && st_d1_ff[2] == st_d2_ff[2]
      |-> prdata == {26'h0, neg_done, 5'h00})
    else $error("base status completion bit wrong");
  a_force_irq_low:
    assert property (pready && pwrite && paddr == 12'h048 && pstrb[0] && pwdata[0]
      |-> ##[1:3] !mgmt_irq_n)
    else $error("test force did not lower interrupt");
  a_irq_off_disabled:
    assert property (pready && pwrite && paddr == 12'h048 && pstrb[0] && pwdata[1:0] == 2'b00
      |-> ##2 mgmt_irq_n)
    else $error("interrupt low with enable and force clear");
endmodule

bind psim_regs psim_regs_asserts chk_u (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .speed_100(speed_100), .tx_active(tx_active), .rx_active(rx_active),
  .collision(collision), .link_up(link_up), .full_duplex(full_duplex),
  .neg_mode(neg_mode), .neg_done(neg_done), .polarity_rev(polarity_rev),
  .pause_cap(pause_cap), .remote_fault(remote_fault), .jabber(jabber),
  .par_det_fault(par_det_fault), .mgmt_irq_n(mgmt_irq_n));

`default_nettype wire

// *** psim_host.sv ***
`timescale 1ns/10ps
`default_nettype none

// management host model: apb master issuing one transfer per call
module psim_host (
  // clock and slave answer
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // apb request
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  // idle bus at time zero
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end

  // setup, access, then hold until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= (a == 12'h048) ? (d & 32'h0000_00F3) : d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

`default_nettype wire

// *** psim_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

// register block bench: apb tasks and directed sequences
module psim_regs_tb;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mgmt_irq_n;
  logic [9:0]  st_v;
  logic [2:0]  flt_v;
  logic [31:0] q;
  logic        e;
  int          n_errors;
  int          compares;
  int          ev_in [4] = '{2, 9, 4, 5};

  psim_host host_u (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb));

  psim_regs dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speed_100(st_v[9]), .tx_active(st_v[8]),
    .rx_active(st_v[7]), .collision(st_v[6]), .link_up(st_v[5]), .full_duplex(st_v[4]),
    .neg_mode(st_v[3]), .neg_done(st_v[2]), .polarity_rev(st_v[1]), .pause_cap(st_v[0]),
    .remote_fault(flt_v[2]), .jabber(flt_v[1]), .par_det_fault(flt_v[0]),
    .mgmt_irq_n(mgmt_irq_n));

  // 50 MHz clock
  always #10 pclk = ~pclk;

  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a);
    host_u.xfer(a, 1'b0, 32'h0000_0000, q, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(a, 1'b1, d, q, e);
  endtask

  // short high pulse on one core status input
  task automatic pulse(input int i);
    st_v[i] <= 1'b1;
    wait_cyc(3);
    st_v[i] <= 1'b0;
    wait_cyc(4);
  endtask

  // watchdog against a hung handshake
  initial begin
    wait_cyc(6000);
    n_errors++;
    report_and_stop();
  end

  // directed sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    st_v = '0;
    flt_v = '0;
    n_errors = 0;
    compares = 0;
    wait_cyc(6);
    presetn <= 1'b1;
    wait_cyc(2);
    chk("irq after reset", 32'(mgmt_irq_n), 32'h1);
    rd(12'h044);
    chk("status two reset", q, 32'h0000_0000);
    rd(12'h048);
    chk("mask reset", q, 32'h0000_0000);
    wr(12'h048, 32'h0000_00F2);
    rd(12'h048);
    chk("mask readback", q, 32'h0000_00F2);
    wr(12'h048, 32'h0000_0001);
    wait_cyc(3);
    chk("irq forced", 32'(mgmt_irq_n), 32'h0);
    wr(12'h048, 32'h0000_0000);
    wait_cyc(3);
    chk("irq unforced", 32'(mgmt_irq_n), 32'h1);
    for (int i = 0; i < 10; i++) begin
      st_v <= 10'h001 << i;
      wait_cyc(3);
      rd(12'h044);
      chk("status two", q, {17'h0, st_v[9:2], 1'b0, st_v[1:0], 4'h0});
    end
    st_v <= 10'h004;
    wait_cyc(3);
    rd(12'h004);
    chk("base status mirror", q, 32'h0000_0020);
    st_v <= '0;
    wait_cyc(3);
    rd(12'h04C);
    for (int k = 0; k < 3; k++) begin
      flt_v <= 3'b001 << k;
      wait_cyc(1);
      flt_v <= '0;
      wait_cyc(3);
      rd(12'h044);
      chk("error bit", 32'(q[3]), 32'h1);
      rd(12'h044);
      chk("error bit kept", 32'(q[3]), 32'h1);
      rd(12'h054);
      chk("error source", q, 32'h1 << k);
      rd(12'h044);
      chk("error bit cleared", 32'(q[3]), 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      wr(12'h048, 32'h0000_0002);
      pulse(ev_in[k]);
      chk("irq event masked", 32'(mgmt_irq_n), 32'h1);
      rd(12'h04C);
      if (k > 0) chk("change flag", 32'(q[7-k]), 32'h1);
      rd(12'h04C);
      if (k > 0) chk("change flag cleared", 32'(q[7-k]), 32'h0);
      wr(12'h048, 32'h80 >> k);
      pulse(ev_in[k]);
      chk("irq globally off", 32'(mgmt_irq_n), 32'h1);
      wr(12'h048, (32'h80 >> k) | 32'h2);
      wait_cyc(3);
      chk("irq raised", 32'(mgmt_irq_n), 32'h0);
      rd(12'h04C);
      chk("irq pending bit", 32'(q[2]), 32'h1);
      wait_cyc(3);
      chk("irq after clear", 32'(mgmt_irq_n), 32'h1);
    end
    rd(12'h100);
    chk("unmapped error", 32'(e), 32'h1);
    chk("unmapped data", q, 32'h0000_0000);
    wr(12'h044, 32'h0000_FFFF);
    rd(12'h044);
    chk("status two write ignored", q, 32'h0000_0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
